// File: rtl/ffs_sequencer.v
// Flat field set sequencer: APB register slave, set table and per-frame set stepping.
// Assumes frame request comes from a pin domain; APB and the datapath run on i_clk.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "ffs_map.vh"

// Summary of operation
// RULE1: While enabled, each acquired frame gets the next set in order.
// RULE2: Sets are indexed 0 to 29, so at most thirty sets exist.
// RULE3: A set carries only the choice of flat field area, nothing else.
// RULE4: The mode control takes 0 for off and 1 for on.
// RULE5: The set count holds how many sets are cycled, accepting 1 to 30.
// RULE6: The bind command names a set from 0 to 29 and an area from 0 to 9.
// RULE7: The reset command returns the set pointer to index 0.
// RULE8: The clear command erases the area chosen by the area selector.
// RULE9: The host must enable flat field correction before relying on the sequencer.
// RULE10: The host should configure count and bindings while the sequencer is off.
// RULE11: Ten flat field areas exist, chosen among by the area selector.
// RULE12: Changes take effect at the rising edge of the frame request.
// RULE13: After set count minus one, the pointer wraps to 0.
module ffs_sequencer
(
	input  wire        i_clk,
	input  wire        i_sys_rst,
	input  wire        i_ce,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output wire        o_pready,
	output wire        o_pslverr,
	output reg  [31:0] o_prdata,
	input  wire        i_frame_req,
	input  wire        i_ffc_en,
	output reg  [3:0]  o_ffc_area,
	output reg         o_area_clear,
	output reg  [3:0]  o_clear_area
);
	reg  [`FFS_AREA_W-1:0] table_area [0:`FFS_NUM_SETS-1];
	reg                    enable;
	reg  [`FFS_SET_W-1:0]  set_count;
	reg  [`FFS_SET_W-1:0]  set_ptr;
	reg  [`FFS_AREA_W-1:0] area_sel;
	reg                    reset_pend;
	reg                    frame_d;
	reg                    param_err;
	reg  [`FFS_SET_W-1:0]  cur_set;
	reg  [`FFS_SET_W-1:0]  next_set_ptr;
	reg  [`FFS_AREA_W-1:0] next_ffc_area;
	reg  [31:0]            next_prdata;
	wire                   frame_lvl;
	wire                   frame_rise;
	wire                   acc;
	wire                   wr;
	wire                   rd_setup;
	wire                   reset_cmd;
	wire                   clear_cmd;
	wire                   count_ok;
	wire                   bind_ok;
	wire                   area_ok;
	wire [`FFS_SET_W-1:0]  w_set;
	wire [`FFS_AREA_W-1:0] w_area;
	wire [`FFS_SET_W-1:0]  w_cnt;
	wire                   mapped;

	ffs_sync3 u_sync
	(
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_ce      (i_ce),
		.i_async   (i_frame_req),
		.o_level   (frame_lvl)
	);

	assign frame_rise = frame_lvl & ~frame_d; // RULE12
	assign acc        = i_psel & i_penable & i_ce;
	assign wr         = acc & i_pwrite;
	// Read data is loaded as the setup cycle ends, so it stands valid through the access cycle.
	assign rd_setup   = i_psel & ~i_penable & ~i_pwrite & i_ce;
	assign o_pready   = 1'b1;
	assign w_set      = i_pwdata[`FFS_BIND_SET_MSB:`FFS_BIND_SET_LSB];
	assign w_area     = i_pwdata[`FFS_BIND_AREA_MSB:`FFS_BIND_AREA_LSB];
	assign w_cnt      = i_pwdata[`FFS_SET_W-1:0];
	assign count_ok   = (w_cnt >= 5'h01) && (w_cnt <= `FFS_COUNT_MAX) &&
	                    (i_pwdata[31:`FFS_SET_W] == 27'h0000000); // RULE5
	assign bind_ok    = (w_set <= `FFS_SET_MAX) && (w_area <= `FFS_AREA_MAX); // RULE2 RULE6
	assign area_ok    = (w_area <= `FFS_AREA_MAX); // RULE11
	assign reset_cmd  = wr & (i_paddr == `FFS_OFF_CMD) & i_pwdata[`FFS_CMD_RESET_BIT];
	assign clear_cmd  = wr & (i_paddr == `FFS_OFF_CMD) & i_pwdata[`FFS_CMD_CLEAR_BIT];
	assign mapped     = (i_paddr == `FFS_OFF_CTRL) || (i_paddr == `FFS_OFF_COUNT) ||
	                    (i_paddr == `FFS_OFF_BIND) || (i_paddr == `FFS_OFF_CMD) ||
	                    (i_paddr == `FFS_OFF_STATUS) || (i_paddr == `FFS_OFF_AREA_SEL);
	assign o_pslverr  = i_psel & i_penable & ~mapped;

	// Table storage: only an area index per set, no other imaging parameter.
	always @(posedge i_clk)
	begin
		if (wr && (i_paddr == `FFS_OFF_BIND) && bind_ok) // RULE6 RULE3
			table_area[w_set] <= w_area;
	end

	// A pending pointer reset makes this frame use set 0, so set 0 is applied once and not twice.
	always @*
	begin
		cur_set       = reset_pend ? {`FFS_SET_W{1'b0}} : set_ptr; // RULE7
		next_set_ptr  = set_ptr;
		next_ffc_area = o_ffc_area;
		if (frame_rise)
		begin
			if (enable)
			begin
				next_ffc_area = table_area[cur_set]; // RULE1
				if (cur_set >= set_count - 5'h01)
					next_set_ptr = {`FFS_SET_W{1'b0}}; // RULE13
				else
					next_set_ptr = cur_set + 5'h01;
			end
			else
			begin
				next_ffc_area = area_sel;
				next_set_ptr  = cur_set;
			end
		end
	end

	always @*
	begin
		case (i_paddr)
			`FFS_OFF_CTRL:     next_prdata = {31'h00000000, enable};
			`FFS_OFF_COUNT:    next_prdata = {27'h0000000, set_count};
			`FFS_OFF_AREA_SEL: next_prdata = {28'h0000000, area_sel};
			`FFS_OFF_STATUS:   next_prdata = {19'h00000, set_ptr, o_ffc_area, 1'b0, param_err, reset_pend,
			                                  i_ffc_en};
			default:           next_prdata = 32'h00000000;
		endcase
	end

	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			enable    <= 1'b0;
			set_count <= `FFS_COUNT_RST;
			area_sel  <= {`FFS_AREA_W{1'b0}};
			param_err <= 1'b0;
		end
		else if (wr)
		begin
			case (i_paddr)
				`FFS_OFF_CTRL:
					enable <= i_pwdata[`FFS_CTRL_EN_BIT]; // RULE4
				`FFS_OFF_COUNT:
				begin
					if (count_ok)
						set_count <= w_cnt; // RULE5
					else
						param_err <= 1'b1;
				end
				`FFS_OFF_BIND:
				begin
					if (!bind_ok)
						param_err <= 1'b1; // RULE2
				end
				`FFS_OFF_AREA_SEL:
				begin
					if (area_ok)
						area_sel <= w_area; // RULE11
					else
						param_err <= 1'b1;
				end
				`FFS_OFF_STATUS:
				begin
					if (i_pwdata[2])
						param_err <= 1'b0;
				end
				default:
					param_err <= param_err;
			endcase
		end
	end

	// Settings only move at the frame request edge so a frame never sees a half change.
	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			frame_d    <= 1'b0;
			set_ptr    <= {`FFS_SET_W{1'b0}};
			reset_pend <= 1'b0;
			o_ffc_area <= 4'h0;
		end
		else if (i_ce)
		begin
			frame_d    <= frame_lvl;
			set_ptr    <= next_set_ptr;
			o_ffc_area <= next_ffc_area;
			// A reset command that meets the frame edge stays pending, so it is never lost.
			if (reset_cmd)
				reset_pend <= 1'b1;
			else if (frame_rise)
				reset_pend <= 1'b0; // RULE7
		end
	end

	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_area_clear <= 1'b0;
			o_clear_area <= 4'h0;
			o_prdata     <= 32'h00000000;
		end
		else if (i_ce)
		begin
			o_area_clear <= clear_cmd; // RULE8
			if (clear_cmd)
				o_clear_area <= area_sel;
			if (rd_setup)
				o_prdata <= next_prdata;
		end
	end
endmodule // ffs_sequencer

// File: rtl/ffs_map.vh
// Register map, field positions, reset values and limits of the flat field set sequencer.
// Assumes plain Verilog-2005 includers; definitions only.
`ifndef FFS_MAP_VH
`define FFS_MAP_VH

`define FFS_OFF_CTRL      12'h000
`define FFS_OFF_COUNT     12'h004
`define FFS_OFF_BIND      12'h008
`define FFS_OFF_CMD       12'h00C
`define FFS_OFF_STATUS    12'h010
`define FFS_OFF_AREA_SEL  12'h014

`define FFS_CTRL_EN_BIT   0
`define FFS_CMD_RESET_BIT 0
`define FFS_CMD_CLEAR_BIT 1
`define FFS_BIND_SET_LSB  8
`define FFS_BIND_SET_MSB  12
`define FFS_BIND_AREA_LSB 0
`define FFS_BIND_AREA_MSB 3

`define FFS_NUM_SETS      30
`define FFS_NUM_AREAS     10
`define FFS_SET_W         5
`define FFS_AREA_W        4
`define FFS_COUNT_RST     5'h01
`define FFS_COUNT_MAX     5'h1E
`define FFS_AREA_MAX      4'h9
`define FFS_SET_MAX       5'h1D

`endif

// File: rtl/ffs_sync3.v
// Three-stage synchroniser with agreement filter for an asynchronous level.
// Assumes the input may change at any time relative to i_clk.
`timescale 1ns/1ps
module ffs_sync3
(
	input  wire i_clk,
	input  wire i_sys_rst,
	input  wire i_ce,
	input  wire i_async,
	output reg  o_level
);
	reg s1;
	reg s2;
	reg s3;

	// The first stage feeds only the second, keeping metastability away from the filter.
	always @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			s1      <= 1'b0;
			s2      <= 1'b0;
			s3      <= 1'b0;
			o_level <= 1'b0;
		end
		else if (i_ce)
		begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				o_level <= s3;
		end
	end
endmodule // ffs_sync3

// File: verif/ffs_chk_properties.sv
// Port checker of the flat field set sequencer.
// Assumes binding onto ffs_sequencer with one clock domain.
`timescale 1ns/1ps
module ffs_chk
(
	input wire        i_clk,
	input wire        i_sys_rst,
	input wire        i_ce,
	input wire        i_pwrite,
	input wire [31:0] i_pwdata,
	input wire        i_psel,
	input wire        i_penable,
	input wire [11:0] i_paddr,
	input wire        o_pslverr,
	input wire        i_frame_req,
	input wire [3:0]  o_ffc_area,
	input wire        o_area_clear
);
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_sys_rst);
wire acc = i_psel && i_penable;
wire clw = acc && i_ce && i_pwrite && i_paddr == 12'h00C && i_pwdata[1];
property p_ar; o_ffc_area <= 4'h9; endproperty
a_ar: assert property (p_ar) else $error("area index out of range");
property p_cp; o_area_clear |=> !o_area_clear; endproperty
a_cp: assert property (p_cp) else $error("clear pulse too long");
property p_cc; $rose(o_area_clear) |-> $past(clw); endproperty
a_cc: assert property (p_cc) else $error("clear without command");
property p_cf; clw |=> o_area_clear; endproperty
a_cf: assert property (p_cf) else $error("clear command without pulse");
property p_fr; $changed(o_ffc_area) |-> $past(i_frame_req, 3); endproperty
a_fr: assert property (p_fr) else $error("area changed off frame");
property p_st; $changed(o_ffc_area) |=> $stable(o_ffc_area)[*4]; endproperty
a_st: assert property (p_st) else $error("area changed twice per frame");
property p_ue; acc && i_paddr > 12'h014 |-> o_pslverr; endproperty
a_ue: assert property (p_ue) else $error("unmapped access accepted");
property p_ok; acc && i_paddr == 12'h004 |-> !o_pslverr; endproperty
a_ok: assert property (p_ok) else $error("count access refused");
property p_ct; acc && i_paddr == 12'h000 |-> !o_pslverr; endproperty
a_ct: assert property (p_ct) else $error("mode access refused");
c_cl: cover property (o_area_clear);
c_ch: cover property ($changed(o_ffc_area));
c_ue: cover property (o_pslverr);
endmodule // ffs_chk
bind ffs_sequencer ffs_chk u_chk (.i_clk, .i_sys_rst, .i_ce, .i_pwrite, .i_pwdata, .i_psel, .i_penable, .i_paddr,
	.o_pslverr, .i_frame_req, .o_ffc_area, .o_area_clear);

// File: verif/ffs_host.sv
// Host model: the APB master that carries the host's commands.
// Assumes each task call begins just after a rising clock edge.
`timescale 1ns/1ps
module ffs_host
(
	input  wire        i_clk,
	input  wire        i_pready,
	output reg         o_psel = 1'b0,
	output reg         o_penable = 1'b0,
	output reg         o_pwrite = 1'b0,
	output reg  [11:0] o_paddr = 12'h000,
	output reg  [31:0] o_pwdata = 32'h0
);
task xf(input reg w, input reg [11:0] a, input reg [31:0] d);
	{o_psel, o_pwrite, o_paddr, o_pwdata} <= {1'b1, w, a, d};
	@(posedge i_clk);
	o_penable <= 1'b1;
	do @(posedge i_clk); while (i_pready !== 1'b1);
	// Data is inverted on release so a stale value is never mistaken for a live one.
	{o_psel, o_penable, o_pwdata} <= {2'b00, ~d};
	@(posedge i_clk);
endtask
endmodule // ffs_host

// File: verif/tb_flat_field_set_sequencer.sv
// Self-checking bench of the flat field set sequencer.
// Assumes ffs_host drives APB while the bench drives the frame pin.
`timescale 1ns/1ps
module tb_flat_field_set_sequencer;
reg i_clk = 1'b0, i_sys_rst = 1'b1, i_frame_req = 1'b0, i_ce = 1'b1, i_ffc_en = 1'b0;
reg [7:0] fsh = 8'h00;
integer seed = 32'hDC2B95B2, miscompares = 0, n_compared = 0, k, tab [0:2];
reg [31:0] qa [$], qc [$], qr [$];
wire i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_area_clear;
wire [11:0] i_paddr;
wire [31:0] i_pwdata, o_prdata;
wire [3:0] o_ffc_area, o_clear_area;
always #12.5 i_clk = ~i_clk;
ffs_host h (.i_clk, .i_pready(o_pready), .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
	.o_paddr(i_paddr), .o_pwdata(i_pwdata));
ffs_sequencer dut_u (.i_clk, .i_sys_rst, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
	.o_pslverr, .o_prdata, .i_frame_req, .i_ffc_en, .o_ffc_area, .o_area_clear, .o_clear_area);
task chk(input string n, input logic [31:0] e, s);
	n_compared = n_compared + 1;
	miscompares = miscompares + (s !== e);
	if (s !== e)
		$display("wrong value %s expected %h seen %h", n, e, s);
endtask
task summarize;
	// Expected results that never showed up count against the run.
	miscompares = miscompares + qa.size() + qc.size() + qr.size();
	$display("compared %0d miscompares %0d", n_compared, miscompares);
	if (miscompares == 0 && n_compared > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
// Frames stay high and low well past the four cycles the synchroniser needs.
task fr(input logic [31:0] e);
	qa.push_back(e);
	i_frame_req <= 1'b1;
	repeat (8) @(posedge i_clk);
	i_frame_req <= 1'b0;
	repeat (8) @(posedge i_clk);
endtask
always @(posedge i_clk)
begin
	fsh <= {fsh[6:0], i_frame_req};
	if (fsh[6] && !fsh[7])
		chk("area", qa.pop_front(), {28'h0, o_ffc_area});
	if (o_area_clear === 1'b1)
		chk("clear area", qc.pop_front(), {28'h0, o_clear_area});
	if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1)
		chk("read data", qr.pop_front(), o_prdata);
end
initial
begin
	#40000 miscompares = miscompares + 1;
	summarize;
end
initial
begin
	repeat (10) @(posedge i_clk);
	i_sys_rst <= 1'b0;
	@(posedge i_clk);
	h.xf(1'b1, 12'h004, 32'h3);
	for (k = 0; k < 3; k = k + 1)
	begin
		tab[k] = {$random(seed)} % 10;
		h.xf(1'b1, 12'h008, {k[23:0], tab[k][7:0]});
	end
	h.xf(1'b1, 12'h008, 32'h0000000A);
	h.xf(1'b1, 12'h004, 32'h1F);
	qr.push_back(32'h3);
	h.xf(1'b0, 12'h004, 32'h0);
	qr.push_back(32'h4);
	h.xf(1'b0, 12'h010, 32'h0);
	h.xf(1'b1, 12'h010, 32'h4);
	i_ce <= 1'b0;
	h.xf(1'b1, 12'h004, 32'h5);
	i_ce <= 1'b1;
	qr.push_back(32'h3);
	h.xf(1'b0, 12'h004, 32'h0);
	h.xf(1'b1, 12'h018, 32'h0);
	i_ffc_en <= 1'b1;
	qr.push_back(32'h1);
	h.xf(1'b0, 12'h010, 32'h0);
	$display("register test done");
	h.xf(1'b1, 12'h000, 32'h1);
	for (k = 0; k < 7; k = k + 1)
		fr(tab[k % 3]);
	h.xf(1'b1, 12'h00C, 32'h1);
	fr(tab[0]);
	fr(tab[1]);
	$display("frame test done");
	h.xf(1'b1, 12'h014, 32'h7);
	qc.push_back(32'h7);
	h.xf(1'b1, 12'h00C, 32'h2);
	h.xf(1'b1, 12'h000, 32'h0);
	fr(32'h7);
	$display("clear test done");
	summarize;
end
endmodule // tb_flat_field_set_sequencer
